// [pkg/fcs_pkg.sv]
// package for the flash command sequencer: offsets, fields, codes, timings and types
package fcs_pkg;
   // register offsets (byte addresses)
   localparam logic [3:0]  ADDR_MODE        = 4'h0;
   localparam logic [3:0]  ADDR_CMD         = 4'h4;
   localparam logic [3:0]  ADDR_STAT        = 4'h8;
   localparam logic [3:0]  ADDR_RES         = 4'hc;
   // key and command codes
   localparam logic [7:0]  CMD_KEY          = 8'h5a;
   localparam logic [7:0]  CMD_ERASE_ALL    = 8'h05;
   localparam logic [7:0]  CMD_SET_LOCK     = 8'h08;
   localparam logic [7:0]  CMD_CLEAR_LOCK   = 8'h09;
   localparam logic [7:0]  CMD_GET_LOCK     = 8'h0a;
   localparam logic [7:0]  CMD_SET_NVBIT    = 8'h0b;
   localparam logic [7:0]  CMD_CLEAR_NVBIT  = 8'h0c;
   localparam logic [7:0]  CMD_GET_NVBIT    = 8'h0d;
   localparam logic [7:0]  CMD_START_UID    = 8'h0e;
   localparam logic [7:0]  CMD_STOP_UID     = 8'h0f;
   localparam logic [7:0]  CMD_GET_TRIM     = 8'h10;
   // field positions
   localparam int          MODE_IRQEN_BIT   = 0;
   localparam int          STAT_READY_BIT   = 0;
   localparam int          STAT_CMDERR_BIT  = 1;
   localparam int          STAT_LOCKERR_BIT = 2;
   localparam int          TRIM8_LSB        = 22;
   localparam int          TRIM12_LSB       = 32;
   localparam int          TRIM_W           = 7;
   localparam int          RES_BITS         = 64;
   // values after reset and fixed values
   localparam logic        READY_RESET      = 1'b1;
   localparam logic [6:0]  TRIM4_VALUE      = 7'h40;
   // timing
   localparam int          CLK_MHZ          = 125;
   localparam int          OP_TIME_NS       = 40;
   localparam int          ERASE_TIME_US    = 1000;
   localparam int          OP_CYCLES        = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int          ERASE_CYCLES     = ERASE_TIME_US * CLK_MHZ;
   localparam int          TW               = 32;
   // command word as written to the command register
   typedef struct packed {
      logic [7:0]  key;
      logic [15:0] arg;
      logic [7:0]  code;
   } fcs_cmd_t;
   // status word layout
   typedef struct packed {
      logic [28:0] zero;
      logic        lockErr;
      logic        cmdErr;
      logic        ready;
   } fcs_stat_t;
   // source of the result register
   typedef enum logic [1:0] {SRC_NONE, SRC_LOCK, SRC_NV, SRC_TRIM} fcs_src_t;
   // sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_UID} fcs_state_t;
endpackage

// [hw/fcs_op_timer.sv]
// operation timer: counts a loaded number of cycles and pulses done at the end
`timescale 1ns/1ns
`default_nettype none
module fcs_op_timer #(
   parameter int W = 32
) (
   input  wire logic         sys_clk,  // system clock
   input  wire logic         reset,    // synchronous reset, high
   input  wire logic         start,    // one-cycle start pulse
   input  wire logic [W-1:0] load,     // cycles to run, at least one
   output logic              busy,     // high while counting
   output logic              done      // one-cycle pulse at the end
);
   logic [W-1:0] count_r;
   logic         busy_r;
   logic         done_r;

   // count down from load, flag the last cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count_r <= '0;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            count_r <= load;
            busy_r  <= 1'b1;
         end else if (busy_r) begin
            if (count_r <= W'(1)) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               count_r <= count_r - W'(1);
            end
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;
endmodule // fcs_op_timer
`default_nettype wire

// [hw/fcs_flash_seq.sv]
// flash command sequencer: keyed commands, lock and nonvolatile bits, trim readout, unique id mode
// How it works
// - erase only when no region locked
// - erase begins right after accepted command
// - completion sets ready except for start-uid, interrupt when enabled
// - locked region rejects whole erase, lock error
// - wrong key sets command error flag
// - set-lock locks region of given page
// - out-of-range lock region changes nothing
// - clear-lock unlocks region of given page
// - get-lock returns lock bits 32 per read
// - flash reads allowed during bit commands
// - set-nvbit sets numbered nonvolatile bit
// - out-of-range nonvolatile bit changes nothing
// - clear-nvbit clears numbered nonvolatile bit, except bit zero
// - get-nvbit returns bits 32 per read
// - nonvolatile and trim bits kept off array
// - trim bits fixed, returned 32 per read
// - trim fields at 28:22 and 38:32
// - nonvolatile bit zero blocks debug access
// - security cleared only by pin-qualified erase
// - start-uid drops ready, maps identifier in
// - stop-uid restores mapping, raises ready
// - command accepted only with key 5a
// - accepted command clears ready and result
// - status read clears both error flags
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module fcs_flash_seq #(
   parameter int         NUM_LOCK     = 16,                  // implemented lock bits (max 64)
   parameter int         NUM_NV       = 2,                   // implemented nonvolatile bits (max 64)
   parameter int         PAGE_LOG2    = 4,                   // log2 of pages per lock region
   parameter int         ERASE_CYCLES = fcs_pkg::ERASE_CYCLES, // erase duration in cycles
   parameter logic [6:0] TRIM8_VALUE  = 7'h40,               // 8 MHz trim value
   parameter logic [6:0] TRIM12_VALUE = 7'h40                // 12 MHz trim value
) (
   input  wire logic          sys_clk,         // system clock, 125 MHz
   input  wire logic          reset,           // synchronous reset, high
   input  wire logic [3:0]    regAddr,         // register byte address
   input  wire logic [31:0]   regWdata,        // register write data
   input  wire logic          regWr,           // write strobe
   input  wire logic          regRd,           // read strobe
   output logic      [31:0]   regRdata,        // read data, cycle after strobe
   input  wire logic          erasePinAsync,   // erase pin, asynchronous
   output logic               flashEraseStart, // pulse: array erase begins
   output logic               eraseBusy,       // array erase in progress
   output logic               flashReadAllow,  // array may serve reads
   output logic               uidMapEnable,    // identifier mapped at array base
   output logic               debugAccessBlock,// security bit set
   output logic [NUM_LOCK-1:0] lockMask,       // lock bit per region
   output logic [6:0]         trimFourMhz,     // fixed 4 MHz trim
   output logic               readyIrq         // ready interrupt level
);
   fcs_pkg::fcs_state_t state_r;
   fcs_pkg::fcs_cmd_t   cmdW;
   fcs_pkg::fcs_src_t   resSrc_r;
   logic [7:0]          curCode_r;
   logic [15:0]         curArg_r;
   logic                curEraseOk_r;
   logic [NUM_LOCK-1:0] lockBits_r;
   logic [NUM_NV-1:0]   nvBits_r;
   logic [1:0]          resIdx_r;
   logic                ready_r, cmdErr_r, lockErr_r, irqEn_r;
   logic                eraseBusy_r, eraseStart_r, uidMode_r, rdValid_r;
   logic [31:0]         regRdata_r;
   logic                pinMeta_r, pinSync_r;
   logic                cmdWr, keyOk, canStart, accept, isErase, eraseOk, lockReject;
   logic                timerDone, eraseDone, statRd, resRd;
   logic [15:0]         region;
   logic [63:0]         trimVec;

   // known command codes
   function automatic logic codeKnown(input logic [7:0] c);
      case (c)
         fcs_pkg::CMD_ERASE_ALL, fcs_pkg::CMD_SET_LOCK, fcs_pkg::CMD_CLEAR_LOCK,
         fcs_pkg::CMD_GET_LOCK, fcs_pkg::CMD_SET_NVBIT, fcs_pkg::CMD_CLEAR_NVBIT,
         fcs_pkg::CMD_GET_NVBIT, fcs_pkg::CMD_START_UID, fcs_pkg::CMD_STOP_UID,
         fcs_pkg::CMD_GET_TRIM: codeKnown = 1'b1;
         default: codeKnown = 1'b0;
      endcase
   endfunction

   // one 32-bit word of a 64-bit result, zero beyond the end
   function automatic logic [31:0] pickWord(input logic [63:0] v, input logic [1:0] idx);
      case (idx)
         2'h0:    pickWord = v[31:0];
         2'h1:    pickWord = v[63:32];
         default: pickWord = 32'h0;
      endcase
   endfunction

   // command decode
   assign cmdW     = fcs_pkg::fcs_cmd_t'(regWdata);
   assign cmdWr    = regWr && (regAddr == fcs_pkg::ADDR_CMD);
   assign keyOk    = (cmdW.key == fcs_pkg::CMD_KEY);
   assign canStart = (state_r == fcs_pkg::ST_IDLE) ||
                     ((state_r == fcs_pkg::ST_UID) && (cmdW.code == fcs_pkg::CMD_STOP_UID));
   assign accept   = cmdWr && keyOk && codeKnown(cmdW.code) && canStart;
   assign isErase  = (cmdW.code == fcs_pkg::CMD_ERASE_ALL);
   // erase only with every region unlocked
   assign eraseOk  = accept && isErase && !(|lockBits_r);
   // any locked region refuses the whole erase
   assign lockReject = accept && isErase && (|lockBits_r);
   assign statRd   = regRd && (regAddr == fcs_pkg::ADDR_STAT);
   assign resRd    = regRd && (regAddr == fcs_pkg::ADDR_RES);
   assign region   = curArg_r >> PAGE_LOG2;
   assign eraseDone = timerDone && (curCode_r == fcs_pkg::CMD_ERASE_ALL) && curEraseOk_r;
   // trim fields placed in the 64-bit readout
   assign trimVec  = {25'h0, TRIM12_VALUE, 3'h0, TRIM8_VALUE, 22'h0};

   // erase pin synchroniser
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pinMeta_r <= 1'b0;
         pinSync_r <= 1'b0;
      end else begin
         pinMeta_r <= erasePinAsync;
         pinSync_r <= pinMeta_r;
      end
   end

   // operation timer, long load for an erase
   fcs_op_timer #(.W(fcs_pkg::TW)) u_timer (
      .sys_clk (sys_clk),
      .reset   (reset),
      .start   (accept),
      .load    (eraseOk ? fcs_pkg::TW'(ERASE_CYCLES) : fcs_pkg::TW'(fcs_pkg::OP_CYCLES)),
      .busy    (),
      .done    (timerDone)
   );

   // sequencer state and latched command
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r      <= fcs_pkg::ST_IDLE;
         curCode_r    <= 8'h00;
         curArg_r     <= 16'h0000;
         curEraseOk_r <= 1'b0;
         uidMode_r    <= 1'b0;
      end else begin
         case (state_r)
            fcs_pkg::ST_IDLE, fcs_pkg::ST_UID: begin
               if (accept) begin
                  state_r      <= fcs_pkg::ST_EXEC;
                  curCode_r    <= cmdW.code;
                  curArg_r     <= cmdW.arg;
                  curEraseOk_r <= eraseOk;
               end
            end
            fcs_pkg::ST_EXEC: begin
               if (timerDone) begin
                  if (curCode_r == fcs_pkg::CMD_START_UID) begin
                     state_r   <= fcs_pkg::ST_UID;
                     uidMode_r <= 1'b1;
                  end else begin
                     state_r <= fcs_pkg::ST_IDLE;
                     if (curCode_r == fcs_pkg::CMD_STOP_UID) begin
                        uidMode_r <= 1'b0;
                     end
                  end
               end
            end
            default: state_r <= fcs_pkg::ST_IDLE;
         endcase
      end
   end

   // ready flag
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ready_r <= fcs_pkg::READY_RESET;
      end else if (accept) begin
         ready_r <= 1'b0;
      end else if (timerDone && (curCode_r != fcs_pkg::CMD_START_UID)) begin
         ready_r <= 1'b1;
      end
   end

   // error flags, a new event wins over the clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cmdErr_r  <= 1'b0;
         lockErr_r <= 1'b0;
      end else begin
         // bad key or refused write flags an error
         if (cmdWr && !accept) begin
            cmdErr_r <= 1'b1;
         // status read or command write clears
         end else if (statRd || cmdWr) begin
            cmdErr_r <= 1'b0;
         end
         if (lockReject) begin
            lockErr_r <= 1'b1;
         end else if (statRd || cmdWr) begin
            lockErr_r <= 1'b0;
         end
      end
   end

   // array erase control
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         eraseBusy_r  <= 1'b0;
         eraseStart_r <= 1'b0;
      end else begin
         eraseStart_r <= eraseOk;
         if (eraseOk) begin
            eraseBusy_r <= 1'b1;
         end else if (eraseDone) begin
            eraseBusy_r <= 1'b0;
         end
      end
   end

   // lock bits, one flop per region
   generate
      for (genvar g = 0; g < NUM_LOCK; g++) begin : gen_lock
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               lockBits_r[g] <= 1'b0;
            // regions past the last never match
            end else if (timerDone && (region == 16'(g))) begin
               if (curCode_r == fcs_pkg::CMD_SET_LOCK) begin
                  lockBits_r[g] <= 1'b1;
               end
               if (curCode_r == fcs_pkg::CMD_CLEAR_LOCK) begin
                  lockBits_r[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // nonvolatile bits held in their own flops, apart from the array
   generate
      for (genvar g = 0; g < NUM_NV; g++) begin : gen_nv
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               nvBits_r[g] <= 1'b0;
            // security bit cleared by erase with pin high, whatever the argument
            end else if ((g == 0) && eraseDone && pinSync_r) begin
               nvBits_r[g] <= 1'b0;
            // numbers past the last never match
            end else if (timerDone && (curArg_r == 16'(g))) begin
               if (curCode_r == fcs_pkg::CMD_SET_NVBIT) begin
                  nvBits_r[g] <= 1'b1;
               end
               // clear-nvbit, never for the security bit
               if ((curCode_r == fcs_pkg::CMD_CLEAR_NVBIT) && (g != 0)) begin
                  nvBits_r[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // result source and word index
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         resSrc_r <= fcs_pkg::SRC_NONE;
         resIdx_r <= 2'h0;
      end else if (accept) begin
         resSrc_r <= fcs_pkg::SRC_NONE;
         resIdx_r <= 2'h0;
      end else if (timerDone) begin
         resIdx_r <= 2'h0;
         case (curCode_r)
            fcs_pkg::CMD_GET_LOCK:  resSrc_r <= fcs_pkg::SRC_LOCK;
            fcs_pkg::CMD_GET_NVBIT: resSrc_r <= fcs_pkg::SRC_NV;
            fcs_pkg::CMD_GET_TRIM:  resSrc_r <= fcs_pkg::SRC_TRIM;
            default:                resSrc_r <= fcs_pkg::SRC_NONE;
         endcase
      end else if (resRd && (resIdx_r != 2'h2)) begin
         resIdx_r <= resIdx_r + 2'h1;
      end
   end

   // mode register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irqEn_r <= 1'b0;
      end else if (regWr && (regAddr == fcs_pkg::ADDR_MODE)) begin
         irqEn_r <= regWdata[fcs_pkg::MODE_IRQEN_BIT];
      end
   end

   // register read data, unmapped reads give zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regRdata_r <= 32'h0;
         rdValid_r  <= 1'b0;
      end else begin
         rdValid_r  <= regRd;
         regRdata_r <= 32'h0;
         if (regRd) begin
            case (regAddr)
               fcs_pkg::ADDR_MODE: regRdata_r <= {31'h0, irqEn_r};
               fcs_pkg::ADDR_STAT: regRdata_r <= fcs_pkg::fcs_stat_t'({29'h0, lockErr_r, cmdErr_r, ready_r});
               fcs_pkg::ADDR_RES: begin
                  case (resSrc_r)
                     fcs_pkg::SRC_LOCK: regRdata_r <= pickWord(64'(lockBits_r), resIdx_r);
                     fcs_pkg::SRC_NV:   regRdata_r <= pickWord(64'(nvBits_r), resIdx_r);
                     fcs_pkg::SRC_TRIM: regRdata_r <= pickWord(trimVec, resIdx_r);
                     default:           regRdata_r <= 32'h0;
                  endcase
               end
               default: regRdata_r <= 32'h0;
            endcase
         end
      end
   end

   // outputs
   assign regRdata         = regRdata_r;
   assign flashEraseStart  = eraseStart_r;
   assign eraseBusy        = eraseBusy_r;
   // only an array erase holds off reads
   assign flashReadAllow   = !eraseBusy_r;
   assign uidMapEnable     = uidMode_r;
   // security bit blocks debug access
   assign debugAccessBlock = nvBits_r[0];
   assign lockMask         = lockBits_r;
   assign trimFourMhz      = fcs_pkg::TRIM4_VALUE;
   assign readyIrq         = ready_r && irqEn_r;
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_bad_key: assert property (cmdWr && !keyOk |=> cmdErr_r && $stable(state_r))
      else $error("bad key did not flag error");
   chk_ready_drop: assert property (accept |=> !ready_r && (resSrc_r == fcs_pkg::SRC_NONE))
      else $error("accept did not clear ready and result");
   chk_erase_start: assert property (eraseOk |=> flashEraseStart ##1 !flashEraseStart && eraseBusy)
      else $error("erase did not start");
   chk_lock_reject: assert property (lockReject |=> lockErr_r && !eraseBusy && !flashEraseStart)
      else $error("locked erase not refused");
   chk_done_ready: assert property (timerDone && (curCode_r != fcs_pkg::CMD_START_UID) |=> ready_r)
      else $error("ready not raised on completion");
   chk_uid_enter: assert property (timerDone && (curCode_r == fcs_pkg::CMD_START_UID)
                                   |=> uidMapEnable && !ready_r)
      else $error("uid mode entry wrong");
   chk_stat_clear: assert property (statRd && !regWr |=> !cmdErr_r && !lockErr_r)
      else $error("status read did not clear errors");
   chk_read_allow: assert property ((state_r == fcs_pkg::ST_EXEC) && (curCode_r != fcs_pkg::CMD_ERASE_ALL)
                                    |-> flashReadAllow)
      else $error("reads blocked during bit command");
   chk_sec_hold: assert property (debugAccessBlock && !(eraseDone && pinSync_r) |=> debugAccessBlock)
      else $error("security bit cleared illegally");
   chk_op_len: assert property (accept && !eraseOk |-> ##[1:8] timerDone)
      else $error("bit command did not finish in time");

   cov_erase: cover property (eraseOk ##[1:1000] eraseDone);
   cov_get_lock: cover property (timerDone && (curCode_r == fcs_pkg::CMD_GET_LOCK) ##[1:20] resRd);
   cov_uid: cover property (uidMode_r ##[1:50] !uidMode_r && ready_r);
endmodule // fcs_flash_seq
`default_nettype wire

// [tb/fcs_flash_seq_tb.sv]
// self-checking bench for the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module fcs_flash_seq_tb;
   localparam int         ERASE_N = 20;
   localparam logic [6:0] T8      = 7'h2b;
   localparam logic [6:0] T12     = 7'h55;
   logic        sys_clk;
   logic        reset;
   logic [3:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdata;
   logic        erasePinAsync;
   logic        flashEraseStart;
   logic        eraseBusy;
   logic        flashReadAllow;
   logic        uidMapEnable;
   logic        debugAccessBlock;
   logic [15:0] lockMask;
   logic [6:0]  trimFourMhz;
   logic        readyIrq;
   int          nErrors;
   int          compares;
   int          eraseStarts;

   fcs_flash_seq #(.NUM_LOCK(16), .NUM_NV(2), .PAGE_LOG2(4), .ERASE_CYCLES(ERASE_N),
      .TRIM8_VALUE(T8), .TRIM12_VALUE(T12)) uut (
      .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .erasePinAsync(erasePinAsync),
      .flashEraseStart(flashEraseStart), .eraseBusy(eraseBusy), .flashReadAllow(flashReadAllow),
      .uidMapEnable(uidMapEnable), .debugAccessBlock(debugAccessBlock), .lockMask(lockMask),
      .trimFourMhz(trimFourMhz), .readyIrq(readyIrq));

   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // counts array erase start pulses
   always @(posedge sys_clk) begin
      if (flashEraseStart === 1'b1) eraseStarts++;
   end

   // compares one value and reports a mismatch
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   // one-cycle register read, data checked in the following cycle
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      check(what, regRdata, exp);
   endtask

   // keyed command write, then a fixed wait
   task automatic cmd(input logic [7:0] code, input logic [15:0] arg, input int n);
      wr(fcs_pkg::ADDR_CMD, {fcs_pkg::CMD_KEY, arg, code});
      repeat (n) @(posedge sys_clk);
   endtask

   // prints the counts and the verdict, then ends the run
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, nErrors);
      if (nErrors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // cuts a hang short
   initial begin
      repeat (5000) @(posedge sys_clk);
      nErrors++;
      report_and_stop();
   end

   // main sequence
   initial begin
      nErrors = 0;
      compares = 0;
      eraseStarts = 0;
      reset = 1'b1;
      regAddr = 4'h0;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      erasePinAsync = 1'b0;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      rd(fcs_pkg::ADDR_STAT, 32'h1, "status reset");
      rd(fcs_pkg::ADDR_MODE, 32'h0, "mode reset");
      rd(4'h2, 32'h0, "unmapped");
      // wrong key is refused and flagged, read clears the flag
      wr(fcs_pkg::ADDR_CMD, 32'h11000008);
      rd(fcs_pkg::ADDR_STAT, 32'h3, "status bad key");
      rd(fcs_pkg::ADDR_STAT, 32'h1, "status cleared");
      check("lock bad key", 32'(lockMask), 32'h0);
      wr(fcs_pkg::ADDR_MODE, 32'h1);
      rd(fcs_pkg::ADDR_MODE, 32'h1, "mode irq");
      // set lock on page 0x35, region 3
      wr(fcs_pkg::ADDR_CMD, {fcs_pkg::CMD_KEY, 16'h0035, fcs_pkg::CMD_SET_LOCK});
      #1;
      check("irq busy", 32'(readyIrq), 32'h0);
      check("read allow", 32'(flashReadAllow), 32'h1);
      repeat (10) @(posedge sys_clk);
      check("lock set", 32'(lockMask), 32'h8);
      check("irq done", 32'(readyIrq), 32'h1);
      cmd(fcs_pkg::CMD_SET_LOCK, 16'h0100, 10);
      check("lock range", 32'(lockMask), 32'h8);
      cmd(fcs_pkg::CMD_GET_LOCK, 16'hffff, 10);
      rd(fcs_pkg::ADDR_RES, 32'h8, "lock word0");
      rd(fcs_pkg::ADDR_RES, 32'h0, "lock word1");
      rd(fcs_pkg::ADDR_RES, 32'h0, "lock extra");
      // erase with a locked region is refused whole
      cmd(fcs_pkg::CMD_ERASE_ALL, 16'h0, 10);
      check("erase refused", 32'(eraseStarts), 32'h0);
      rd(fcs_pkg::ADDR_STAT, 32'h5, "status lock err");
      cmd(fcs_pkg::CMD_CLEAR_LOCK, 16'h0035, 10);
      check("lock clear", 32'(lockMask), 32'h0);
      // nonvolatile bits, bit 2 is out of range
      cmd(fcs_pkg::CMD_SET_NVBIT, 16'h0, 10);
      cmd(fcs_pkg::CMD_SET_NVBIT, 16'h1, 10);
      cmd(fcs_pkg::CMD_SET_NVBIT, 16'h2, 10);
      check("security", 32'(debugAccessBlock), 32'h1);
      cmd(fcs_pkg::CMD_GET_NVBIT, 16'h0, 10);
      rd(fcs_pkg::ADDR_RES, 32'h3, "nv set");
      rd(fcs_pkg::ADDR_RES, 32'h0, "nv extra");
      cmd(fcs_pkg::CMD_CLEAR_NVBIT, 16'h1, 10);
      cmd(fcs_pkg::CMD_CLEAR_NVBIT, 16'h2, 10);
      cmd(fcs_pkg::CMD_CLEAR_NVBIT, 16'h0, 10);
      cmd(fcs_pkg::CMD_GET_NVBIT, 16'h0, 10);
      rd(fcs_pkg::ADDR_RES, 32'h1, "nv clear");
      // erase with pin low keeps security, with pin high drops it
      wr(fcs_pkg::ADDR_CMD, {fcs_pkg::CMD_KEY, 16'h0, fcs_pkg::CMD_ERASE_ALL});
      #1;
      check("erase busy", 32'(eraseBusy), 32'h1);
      check("erase read hold", 32'(flashReadAllow), 32'h0);
      repeat (ERASE_N + 10) @(posedge sys_clk);
      check("erase count", 32'(eraseStarts), 32'h1);
      check("erase end", 32'(eraseBusy), 32'h0);
      check("security kept", 32'(debugAccessBlock), 32'h1);
      erasePinAsync <= 1'b1;
      cmd(fcs_pkg::CMD_ERASE_ALL, 16'h0, ERASE_N + 10);
      check("security off", 32'(debugAccessBlock), 32'h0);
      erasePinAsync <= 1'b0;
      // trim readout
      cmd(fcs_pkg::CMD_GET_TRIM, 16'h0, 10);
      rd(fcs_pkg::ADDR_RES, {3'h0, T8, 22'h0}, "trim word0");
      rd(fcs_pkg::ADDR_RES, {25'h0, T12}, "trim word1");
      rd(fcs_pkg::ADDR_RES, 32'h0, "trim extra");
      check("trim 4", 32'(trimFourMhz), 32'h40);
      // identifier mode: other commands refused until stop
      // no array fetch: only register accesses here
      cmd(fcs_pkg::CMD_START_UID, 16'h0, 10);
      check("uid on", 32'(uidMapEnable), 32'h1);
      rd(fcs_pkg::ADDR_STAT, 32'h0, "status uid");
      cmd(fcs_pkg::CMD_SET_LOCK, 16'h0, 2);
      rd(fcs_pkg::ADDR_STAT, 32'h2, "status uid err");
      cmd(fcs_pkg::CMD_STOP_UID, 16'h0, 10);
      check("uid off", 32'(uidMapEnable), 32'h0);
      check("uid irq", 32'(readyIrq), 32'h1);
      rd(fcs_pkg::ADDR_STAT, 32'h1, "status stop");
      check("lock uid", 32'(lockMask), 32'h0);
      report_and_stop();
   end
endmodule // fcs_flash_seq_tb
`default_nettype wire
